// File: usic_pkg.sv
// constants and types shared by the serial port status and control block
package usic_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_BAUD = 8'h08;
	localparam logic [7:0] OFF_TX_DATA = 8'h0C;
	localparam logic [7:0] OFF_RX_DATA = 8'h10;

	// serial_status_control bit positions
	localparam int B_TXSEL1 = 15;
	localparam int B_TX_INVERT = 14;
	localparam int B_TXSEL0 = 13;
	localparam int B_BRK = 11;
	localparam int B_TXEN = 10;
	localparam int B_TXBF = 9;
	localparam int B_TX_EMPTY = 8;
	localparam int B_RXSEL1 = 7;
	localparam int B_RXSEL0 = 6;
	localparam int B_ADDR_DETECT = 5;
	localparam int B_RX_IDLE = 4;
	localparam int B_PARITY_ERR = 3;
	localparam int B_FRAME_ERR = 2;
	localparam int B_OVR = 1;
	localparam int B_RXDA = 0;

	// mode register bit positions
	localparam int B_CODEC_EN = 12;
	localparam int B_FORMAT_LO = 1;
	localparam int B_STSEL = 0;

	typedef enum logic [1:0] {
		PDS_8N = 2'b00,
		PDS_8E = 2'b01,
		PDS_8O = 2'b10,
		PDS_9N = 2'b11
	} usic_format_t;

	// interrupt select codes
	localparam logic [1:0] TXI_EACH = 2'b00;
	localparam logic [1:0] TXI_DONE = 2'b01;
	localparam logic [1:0] TXI_EMPTY = 2'b10;
	localparam logic [1:0] RXI_FULL = 2'b11;
	localparam logic [1:0] RXI_3Q = 2'b10;
	localparam int RX_LVL_FULL = 4;
	localparam int RX_LVL_3Q = 3;

	// line timing
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] IR_PULSE = 4'h3;
	localparam int BRK_ZEROS = 12;
	localparam logic [15:0] BAUD_RST = 16'h0000;

	typedef struct packed {
		logic parityErr;
		logic frameErr;
		logic [8:0] data;
	} usic_rx_entry_t;

	typedef struct packed {
		logic [15:0] bits;
		logic [3:0] last;
	} usic_frame_t;

endpackage

// File: usic_top.sv
// serial port: status/control register, transmitter, receiver, bus slave
`timescale 1ns/1ps
// Function
// R1 - select 10: irq when move empties buffer
// R2 - select 00: irq on each buffer-to-shift move
// R3 - select 01: irq when last character done
// R4 - codec off: invert makes line idle low
// R5 - codec on: invert makes encoded idle high
// R6 - break: start, twelve zeros, stop, auto-clear
// R7 - disable aborts, flushes, releases pin
// R8 - buffer-full flag when no room
// R9 - empty flag when shifter and buffer empty
// R10 - rx select 11: irq at four characters
// R11 - rx select 10: irq at three characters
// R12 - rx select 0x: irq on every character
// R13 - address detect only in nine-bit mode
// R14 - idle flag high unless receiving
// R15 - parity flag follows FIFO head
// R16 - framing flag follows FIFO head
// R17 - overflow sets flag; clearing flushes receiver
// R18 - data-available while FIFO not empty
// R19 - reading data advances FIFO head
// R20 - nine-bit mode is select 11
// R21 - only software clears overrun flag
// R22 - address mode drops ninth-bit-zero characters
// R23 - four-deep FIFO with per-character flags
module usic_top #(
	parameter int TX_DEPTH = 4,
	parameter int RX_DEPTH = 4
) (
	input wire logic clk, // 125 MHz
	input wire logic rst_b, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic rxIn, // receive line
	output logic txOut, // transmit line or encoded output
	output logic txOe, // serial port owns tx pin
	output logic txIrq, // transmit interrupt pulse
	output logic rxIrq // receive interrupt pulse
);
	import usic_pkg::*;

	localparam int TPW = $clog2(TX_DEPTH);
	localparam int RPW = $clog2(RX_DEPTH);

	logic [1:0] txSel_q, rxSel_q;
	logic tx_polarity_invert_q, brk_q, txEn_q, addrEn_q, ovr_q;
	logic infrared_codec_enable_q, stopTwo_q;
	usic_format_t fmtSel_q;
	logic [15:0] baud_q, baudCnt_q;
	logic baudTick;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic apbDone, wrStatus, wrTx, rdRx;
	logic ovrClear;

	// transmitter
	logic [8:0] txMem [TX_DEPTH];
	logic [TPW-1:0] txWp_q, txRp_q;
	logic [TPW:0] txCnt_q;
	logic txPush, txPop, txFull;
	typedef enum {TX_IDLE, TX_SHIFT} usic_tx_state_t;
	usic_tx_state_t txSt_q;
	usic_frame_t txFrm_q;
	logic [3:0] txSub_q, txIdx_q;
	logic txBrkRun_q, txEnd, txBit, irPulse;
	logic txOut_q, txOe_q, txIrq_q;

	// receiver
	usic_rx_entry_t rxMem [RX_DEPTH];
	logic [RPW-1:0] rxWp_q, rxRp_q;
	logic [RPW:0] rxCnt_q;
	typedef enum {RX_IDLE, RX_START, RX_BITS} usic_rx_state_t;
	usic_rx_state_t rxSt_q;
	logic [3:0] rxSub_q, rxIdx_q, rxLast;
	logic [9:0] rxShift_q;
	logic rxDone, rxStore, rxPop, rxPush, rxFrameBad, rxParityBad;
	logic rxIrq_q;
	logic nineBit, parOn;
	usic_rx_entry_t rxHead;

	assign nineBit = (fmtSel_q == PDS_9N); // R20
	assign parOn = (fmtSel_q == PDS_8E) || (fmtSel_q == PDS_8O);

	// frame image, lsb first, stop bits already in the ones above
	function automatic usic_frame_t build_frame(input logic [8:0] d, input usic_format_t ps,
			input logic two, input logic brk);
		usic_frame_t f;
		int n;
		f.bits = '1;
		f.bits[0] = 1'b0;
		if (brk) begin
			for (int i = 1; i <= BRK_ZEROS; i++) begin
				f.bits[i] = 1'b0; // R6
			end
			n = BRK_ZEROS + 2;
		end else begin
			f.bits[8:1] = d[7:0];
			n = 9;
			if (ps == PDS_9N) begin
				f.bits[9] = d[8];
				n = 10;
			end else if (ps != PDS_8N) begin
				f.bits[9] = (ps == PDS_8E) ? ^d[7:0] : ~^d[7:0];
				n = 10;
			end
			n = n + 1 + (two ? 1 : 0);
		end
		f.last = 4'(n - 1);
		return f;
	endfunction

	// apb: ready one cycle into the access phase, data and effects at that edge
	assign apbDone = psel && penable && pready_q;
	assign wrStatus = apbDone && pwrite && (paddr == OFF_STATUS_CONTROL);
	assign wrTx = apbDone && pwrite && (paddr == OFF_TX_DATA);
	assign rdRx = apbDone && !pwrite && (paddr == OFF_RX_DATA);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !(paddr == OFF_STATUS_CONTROL
				|| paddr == OFF_MODE || paddr == OFF_BAUD || paddr == OFF_TX_DATA
				|| paddr == OFF_RX_DATA);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata_q <= '0;
		end else if (psel && penable && !pready_q && !pwrite) begin
			prdata_q <= '0;
			case (paddr)
				OFF_STATUS_CONTROL: begin
					prdata_q[B_TXSEL1] <= txSel_q[1];
					prdata_q[B_TX_INVERT] <= tx_polarity_invert_q;
					prdata_q[B_TXSEL0] <= txSel_q[0];
					prdata_q[B_BRK] <= brk_q;
					prdata_q[B_TXEN] <= txEn_q;
					prdata_q[B_TXBF] <= txFull; // R8
					prdata_q[B_TX_EMPTY] <= (txSt_q == TX_IDLE) && (txCnt_q == '0); // R9
					prdata_q[B_RXSEL1] <= rxSel_q[1];
					prdata_q[B_RXSEL0] <= rxSel_q[0];
					prdata_q[B_ADDR_DETECT] <= addrEn_q;
					prdata_q[B_RX_IDLE] <= (rxSt_q == RX_IDLE); // R14
					prdata_q[B_PARITY_ERR] <= (rxCnt_q != '0) && rxHead.parityErr; // R15
					prdata_q[B_FRAME_ERR] <= (rxCnt_q != '0) && rxHead.frameErr; // R16
					prdata_q[B_OVR] <= ovr_q;
					prdata_q[B_RXDA] <= (rxCnt_q != '0); // R18
				end
				OFF_MODE: begin
					prdata_q[B_CODEC_EN] <= infrared_codec_enable_q;
					prdata_q[B_FORMAT_LO +: 2] <= fmtSel_q;
					prdata_q[B_STSEL] <= stopTwo_q;
				end
				OFF_BAUD: prdata_q[15:0] <= baud_q;
				OFF_RX_DATA: prdata_q[8:0] <= (rxCnt_q != '0) ? rxHead.data : 9'h000;
				default: prdata_q <= '0;
			endcase
		end
	end

	// control fields
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txSel_q <= 2'b00;
			rxSel_q <= 2'b00;
			tx_polarity_invert_q <= 1'b0;
			txEn_q <= 1'b0;
			addrEn_q <= 1'b0;
		end else if (wrStatus) begin
			txSel_q <= {pwdata[B_TXSEL1], pwdata[B_TXSEL0]};
			rxSel_q <= {pwdata[B_RXSEL1], pwdata[B_RXSEL0]};
			tx_polarity_invert_q <= pwdata[B_TX_INVERT];
			txEn_q <= pwdata[B_TXEN];
			addrEn_q <= pwdata[B_ADDR_DETECT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			infrared_codec_enable_q <= 1'b0;
			fmtSel_q <= PDS_8N;
			stopTwo_q <= 1'b0;
			baud_q <= BAUD_RST;
		end else if (apbDone && pwrite) begin
			if (paddr == OFF_MODE) begin
				infrared_codec_enable_q <= pwdata[B_CODEC_EN];
				fmtSel_q <= usic_format_t'(pwdata[B_FORMAT_LO +: 2]);
				stopTwo_q <= pwdata[B_STSEL];
			end
			if (paddr == OFF_BAUD) begin
				baud_q <= pwdata[15:0];
			end
		end
	end

	// break request: hardware clear at end of break frame beats the write
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			brk_q <= 1'b0;
		end else if (txEnd && txBrkRun_q) begin
			brk_q <= 1'b0; // R6
		end else if (wrStatus) begin
			brk_q <= pwdata[B_BRK];
		end
	end

	// overrun: a new overflow in the clearing cycle keeps the flag set
	assign ovrClear = wrStatus && ovr_q && !pwdata[B_OVR];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovr_q <= 1'b0;
		end else if (rxStore && rxCnt_q == (RPW+1)'(RX_DEPTH)) begin
			ovr_q <= 1'b1; // R17
		end else if (ovrClear) begin
			ovr_q <= 1'b0; // R21
		end
	end

	// 16x oversampling tick; a new divisor restarts the count
	always_ff @(posedge clk) begin
		if (!rst_b || (apbDone && pwrite && paddr == OFF_BAUD)) begin
			baudCnt_q <= '0;
		end else if (baudTick) begin
			baudCnt_q <= '0;
		end else begin
			baudCnt_q <= baudCnt_q + 16'h0001;
		end
	end
	assign baudTick = (baudCnt_q == baud_q);

	// transmit buffer
	assign txFull = (txCnt_q == (TPW+1)'(TX_DEPTH));
	assign txPush = wrTx && !txFull && txEn_q;
	assign txPop = (txSt_q == TX_IDLE) && txEn_q && (txCnt_q != '0);

	always_ff @(posedge clk) begin
		if (txPush) begin
			txMem[txWp_q] <= pwdata[8:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !txEn_q) begin
			txWp_q <= '0; // R7
			txRp_q <= '0;
			txCnt_q <= '0;
		end else begin
			if (txPush) begin
				txWp_q <= txWp_q + 1'b1;
			end
			if (txPop) begin
				txRp_q <= txRp_q + 1'b1;
			end
			txCnt_q <= txCnt_q + (TPW+1)'(txPush) - (TPW+1)'(txPop);
		end
	end

	// transmit shifter
	assign txEnd = (txSt_q == TX_SHIFT) && baudTick && txSub_q == OVS_LAST
		&& txIdx_q == txFrm_q.last;

	always_ff @(posedge clk) begin
		if (!rst_b || !txEn_q) begin
			txSt_q <= TX_IDLE; // R7
			txSub_q <= '0;
			txIdx_q <= '0;
			txBrkRun_q <= 1'b0;
			txFrm_q <= '1;
		end else begin
			case (txSt_q)
				TX_IDLE: begin
					if (txPop) begin
						txFrm_q <= build_frame(txMem[txRp_q], fmtSel_q, stopTwo_q, brk_q);
						txBrkRun_q <= brk_q;
						txSub_q <= '0;
						txIdx_q <= '0;
						txSt_q <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (baudTick) begin
						txSub_q <= txSub_q + 4'h1;
						if (txSub_q == OVS_LAST) begin
							txIdx_q <= txIdx_q + 4'h1;
							if (txIdx_q == txFrm_q.last) begin
								txSt_q <= TX_IDLE;
							end
						end
					end
				end
				default: txSt_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txIrq_q <= 1'b0;
		end else begin
			case (txSel_q)
				TXI_EACH: txIrq_q <= txPop; // R2
				TXI_EMPTY: txIrq_q <= txPop && txCnt_q == (TPW+1)'(1) && !txPush; // R1
				TXI_DONE: txIrq_q <= txEnd && txCnt_q == '0; // R3
				default: txIrq_q <= 1'b0; // select 11: no irq
			endcase
		end
	end

	// line drive; encoded mode pulses for 3/16 of each zero bit
	assign txBit = (txSt_q == TX_SHIFT) ? txFrm_q.bits[txIdx_q] : 1'b1;
	assign irPulse = (txSt_q == TX_SHIFT) && !txBit && (txSub_q < IR_PULSE);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txOut_q <= 1'b1;
			txOe_q <= 1'b0;
		end else begin
			txOe_q <= txEn_q; // R7
			if (infrared_codec_enable_q) begin
				txOut_q <= irPulse ^ tx_polarity_invert_q; // R5
			end else begin
				txOut_q <= txBit ^ tx_polarity_invert_q; // R4
			end
		end
	end

	// receiver: start checked at mid-bit, later bits sampled 16 ticks apart
	assign rxLast = 4'(8 + (nineBit ? 1 : 0) + (parOn ? 1 : 0));
	assign rxDone = (rxSt_q == RX_BITS) && baudTick && rxSub_q == OVS_LAST
		&& rxIdx_q == rxLast;
	assign rxFrameBad = !rxIn;
	assign rxParityBad = parOn && (rxShift_q[8] != ((fmtSel_q == PDS_8E) ? ^rxShift_q[7:0]
		: ~^rxShift_q[7:0]));
	assign rxStore = rxDone && !(addrEn_q && nineBit && !rxShift_q[8]); // R13 R22

	always_ff @(posedge clk) begin
		if (!rst_b || ovrClear) begin
			rxSt_q <= RX_IDLE; // R17
			rxSub_q <= '0;
			rxIdx_q <= '0;
			rxShift_q <= '0;
		end else if (baudTick) begin
			case (rxSt_q)
				RX_IDLE: begin
					rxSub_q <= '0;
					if (!rxIn) begin
						rxSt_q <= RX_START;
					end
				end
				RX_START: begin
					rxSub_q <= rxSub_q + 4'h1;
					if (rxIn) begin
						rxSt_q <= RX_IDLE;
					end else if (rxSub_q == OVS_MID) begin
						rxSub_q <= '0;
						rxIdx_q <= '0;
						rxSt_q <= RX_BITS;
					end
				end
				RX_BITS: begin
					rxSub_q <= rxSub_q + 4'h1;
					if (rxSub_q == OVS_LAST) begin
						rxIdx_q <= rxIdx_q + 4'h1;
						if (rxIdx_q < rxLast) begin
							rxShift_q[rxIdx_q] <= rxIn;
						end else begin
							rxSt_q <= RX_IDLE;
						end
					end
				end
				default: rxSt_q <= RX_IDLE;
			endcase
		end
	end

	// receive FIFO; a full FIFO drops the new character
	assign rxHead = rxMem[rxRp_q];
	assign rxPush = rxStore && rxCnt_q != (RPW+1)'(RX_DEPTH) && !ovrClear;
	assign rxPop = rdRx && rxCnt_q != '0 && !ovrClear; // R19

	always_ff @(posedge clk) begin
		if (rxPush) begin
			// shifter bit 8 holds parity or a stale ninth bit outside nine-bit mode
			rxMem[rxWp_q] <= '{parityErr: rxParityBad, frameErr: rxFrameBad,
				data: {nineBit && rxShift_q[8], rxShift_q[7:0]}}; // R23
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || ovrClear) begin
			rxWp_q <= '0; // R17
			rxRp_q <= '0;
			rxCnt_q <= '0;
		end else begin
			if (rxPush) begin
				rxWp_q <= rxWp_q + 1'b1;
			end
			if (rxPop) begin
				rxRp_q <= rxRp_q + 1'b1; // R19
			end
			rxCnt_q <= rxCnt_q + (RPW+1)'(rxPush) - (RPW+1)'(rxPop);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rxIrq_q <= 1'b0;
		end else begin
			case (rxSel_q)
				RXI_FULL: rxIrq_q <= rxPush && rxCnt_q == (RPW+1)'(RX_LVL_FULL - 1); // R10
				RXI_3Q: rxIrq_q <= rxPush && rxCnt_q == (RPW+1)'(RX_LVL_3Q - 1); // R11
				default: rxIrq_q <= rxPush; // R12
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txOut = txOut_q;
	assign txOe = txOe_q;
	assign txIrq = txIrq_q;
	assign rxIrq = rxIrq_q;

endmodule // usic_top

// File: usic_checker.sv
// bus and pin checks for the serial port
`timescale 1ns/1ps
module usic_checker (
	input wire logic clk, // clock
	input wire logic rst_b, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic txOut, // tx line
	input wire logic txOe, // pin owned
	input wire logic txIrq, // tx irq
	input wire logic rxIrq // rx irq
);
	import usic_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	ready_wait_a: assert property (
		psel && !penable |-> ##2 (pready && psel && penable))
		else $error("bus answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	status_map_a: assert property (pready && paddr == OFF_STATUS_CONTROL |->
		!pslverr && prdata[31:16] == 16'h0000 && !prdata[12])
		else $error("status word bad");
	err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("error read not zero");
	txoe_follow_a: assert property (
		pready && pwrite && paddr == OFF_STATUS_CONTROL |=> ##1 txOe == $past(pwdata[B_TXEN], 2))
		else $error("pin owner wrong");
	txirq_pulse_a: assert property (txIrq |=> (!txIrq) [*2])
		else $error("tx irq too long");
	rxirq_pulse_a: assert property (rxIrq |=> (!rxIrq) [*8])
		else $error("rx irq too long");
	reset_idle_a: assert property (
		disable iff (1'b0) !rst_b |=> txOut && !txOe && !pready && !txIrq && !rxIrq)
		else $error("reset state wrong");
	tx_irq_c: cover property (txIrq);
	rx_irq_c: cover property (rxIrq);
	bus_err_c: cover property (pready && pslverr);
endmodule // usic_checker

// File: usic_peer.sv
// far end serial transceiver model
`timescale 1ns/1ps
module usic_peer #(
	parameter int BIT_CLKS = 16 // divisor 0: one tick a clock
) (
	input wire logic clk, // clock
	input wire logic txLine, // from block
	output logic rxLine // to block
);
	initial rxLine = 1'b1;
	// lsb first; line idles high after the frame
	task automatic send(input logic [15:0] frame, input int n);
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxLine <= frame[i];
			repeat (BIT_CLKS) @(posedge clk);
		end
		rxLine <= 1'b1;
	endtask
	// mid-bit sampling; returns inside the last bit
	task automatic getBits(input int n, output logic [15:0] bits);
		bits = 16'h0000;
		@(negedge txLine);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = txLine;
			if (i < n - 1) repeat (BIT_CLKS) @(posedge clk);
		end
	endtask
endmodule // usic_peer

// File: usic_top_tb.sv
// testbench for the serial port status and control block
`timescale 1ns/1ps
bind usic_top usic_checker i_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .txOut, .txOe, .txIrq, .rxIrq);
module usic_top_tb;
	import usic_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, errSeen;
	logic rxIn, txOut, txOe, txIrq, rxIrq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] fr;
	logic [1:0] txSel [3] = '{TXI_EACH, TXI_EMPTY, TXI_DONE};
	int badCount, totalChecks, cyc, txCnt, rxCnt, base;
	usic_top i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxIn, .txOut, .txOe, .txIrq, .rxIrq);
	usic_peer i_peer (.clk, .txLine(txOut), .rxLine(rxIn));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (txIrq === 1'b1) txCnt <= txCnt + 1;
		if (rxIrq === 1'b1) rxCnt <= rxCnt + 1;
		if (cyc == 20000) begin
			badCount++;
			results;
		end
	end
	task results;
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// waits on ready, request held until then; a hang ends at the run timeout
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("ready wait", 32'h2, n);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task idleChk(input logic [31:0] mode, input logic [31:0] st, input logic exp);
		wr(OFF_MODE, mode);
		wr(OFF_STATUS_CONTROL, st);
		repeat (3) @(posedge clk);
		chk("idle level", {31'h0, exp}, {31'h0, txOut});
	endtask
	function automatic int rxExp(input int s, input int k);
		if (s == 3) return k == 4;
		if (s == 2) return k >= 3;
		return k;
	endfunction
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rdChk("reset status", OFF_STATUS_CONTROL, 32'h0110);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, errSeen});
		wr(OFF_STATUS_CONTROL, 32'h0400);
		repeat (3) @(posedge clk);
		foreach (txSel[i]) begin
			wr(OFF_STATUS_CONTROL, {16'h0, txSel[i][1], 1'b0, txSel[i][0], 13'h0400});
			base = txCnt;
			fork
				wr(OFF_TX_DATA, 32'h55);
				i_peer.getBits(10, fr);
			join
			chk("tx frame", 32'h02AA, {16'h0, fr});
			chk("tx irq early", {31'h0, txSel[i] != TXI_DONE}, txCnt - base);
			repeat (24) @(posedge clk);
			chk("tx irq late", 32'h1, txCnt - base);
		end
		wr(OFF_STATUS_CONTROL, 32'h0400);
		repeat (6) wr(OFF_TX_DATA, 32'h0F);
		rdChk("tx full", OFF_STATUS_CONTROL, 32'h0610);
		wr(OFF_STATUS_CONTROL, 32'h0);
		repeat (2) @(posedge clk);
		chk("pin released", 32'h0, {31'h0, txOe});
		rdChk("aborted", OFF_STATUS_CONTROL, 32'h0110);
		wr(OFF_STATUS_CONTROL, 32'h0400);
		repeat (40) @(posedge clk);
		rdChk("flushed tx", OFF_STATUS_CONTROL, 32'h0510);
		wr(OFF_STATUS_CONTROL, 32'h0C00);
		fork
			wr(OFF_TX_DATA, 32'h0);
			i_peer.getBits(14, fr);
		join
		chk("break frame", 32'h2000, {16'h0, fr});
		repeat (24) @(posedge clk);
		rdChk("break done", OFF_STATUS_CONTROL, 32'h0510);
		idleChk(32'h0, 32'h4400, 1'b0);
		idleChk(32'h0, 32'h0400, 1'b1);
		idleChk(32'h1000, 32'h4400, 1'b1);
		idleChk(32'h1000, 32'h0400, 1'b0);
		// odd parity with two stop bits; status read lands inside the second stop
		wr(OFF_MODE, 32'h0005);
		rdChk("mode back", OFF_MODE, 32'h0005);
		wr(OFF_BAUD, 32'h1234);
		rdChk("baud back", OFF_BAUD, 32'h1234);
		wr(OFF_BAUD, 32'h0);
		fork
			wr(OFF_TX_DATA, 32'h55);
			i_peer.getBits(12, fr);
		join
		chk("odd frame", 32'h0EAA, {16'h0, fr});
		rdChk("second stop", OFF_STATUS_CONTROL, 32'h0410);
		wr(OFF_MODE, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wr(OFF_STATUS_CONTROL, {24'h0, s[1:0], 6'h0});
			base = rxCnt;
			for (int k = 1; k <= 4; k++) begin
				i_peer.send({7'h7F, 8'hA0 + k[7:0], 1'b0}, 10);
				repeat (4) @(posedge clk);
				chk("rx irq count", rxExp(s, k), rxCnt - base);
			end
			rdChk("rx full", OFF_STATUS_CONTROL, {24'h01, s[1:0], 6'h11});
			if (s < 3) begin
				for (int k = 1; k <= 4; k++) rdChk("rx data", OFF_RX_DATA, 32'hA0 + k);
			end else begin
				i_peer.send(16'hFFFE, 10);
				repeat (40) @(posedge clk);
				rdChk("overrun", OFF_STATUS_CONTROL, 32'h01D3);
				wr(OFF_STATUS_CONTROL, 32'h0);
				rdChk("rx flushed", OFF_STATUS_CONTROL, 32'h0110);
			end
		end
		wr(OFF_MODE, 32'h0002);
		i_peer.send({5'h1F, 1'b1, 1'b0, 8'h01, 1'b0}, 11);
		i_peer.send({5'h1F, 1'b0, 1'b0, 8'h03, 1'b0}, 11);
		repeat (4) @(posedge clk);
		rdChk("parity head", OFF_STATUS_CONTROL, 32'h0119);
		rdChk("char one", OFF_RX_DATA, 32'h01);
		rdChk("framing head", OFF_STATUS_CONTROL, 32'h0115);
		rdChk("char two", OFF_RX_DATA, 32'h03);
		rdChk("rx empty", OFF_STATUS_CONTROL, 32'h0110);
		wr(OFF_MODE, 32'h0006);
		wr(OFF_STATUS_CONTROL, 32'h0020);
		i_peer.send({5'h1F, 1'b1, 9'h055, 1'b0}, 11);
		i_peer.send({5'h1F, 1'b1, 9'h1A5, 1'b0}, 11);
		repeat (4) @(posedge clk);
		rdChk("addr only", OFF_STATUS_CONTROL, 32'h0131);
		rdChk("addr char", OFF_RX_DATA, 32'h01A5);
		wr(OFF_MODE, 32'h0);
		i_peer.send({7'h7F, 8'h12, 1'b0}, 10);
		repeat (4) @(posedge clk);
		rdChk("8-bit kept", OFF_RX_DATA, 32'h12);
		results;
	end
endmodule // usic_top_tb
